// [hw/aspc_pkg.sv]
// Purpose: Shared constants for the angle sensor serial port, both ends
// Assumes: core_clk at 50 MHz; link pins sampled by core_clk
// Notes: Function
package aspc_pkg;
  // Clock and timing, times in their printed units
  localparam int CLK_NS = 20;
  localparam int REFRESH_NS = 1000;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
  localparam int SSI_TM_NS = 25000;
  localparam int SSI_TM_CYC = (SSI_TM_NS + CLK_NS - 1) / CLK_NS;
  localparam int SSI_DEAD_NS = 40000;
  localparam int SSI_DEAD_CYC = (SSI_DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_ANG_NS = 150;
  localparam int IDLE_ANG_CYC = (IDLE_ANG_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_REG_NS = 750;
  localparam int IDLE_REG_CYC = (IDLE_REG_NS + CLK_NS - 1) / CLK_NS;
  localparam int NVM_MS = 20;
  localparam int NVM_CYC_DEF = (NVM_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF_DEF = 8;
  localparam int ANGLE_BITS_DEF = 14;
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int SSI_CLOCKS = 17;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h4;
  localparam int OP_MSB = 15;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;
  // Device registers and fields
  localparam logic [4:0] REG_ROT_DIR = 5'h09;
  localparam logic [4:0] REG_FIELD = 5'h1b;
  localparam int ROT_DIR_BIT = 7;
  localparam int FIELD_HIGH_BIT = 7;
  localparam int FIELD_LOW_BIT = 6;
  // Host software registers and fields
  localparam logic [1:0] HREG_CTRL = 2'h0;
  localparam logic [1:0] HREG_STAT = 2'h1;
  localparam logic [1:0] HREG_REPLY = 2'h2;
  localparam logic [1:0] HOP_ANGLE = 2'h0;
  localparam logic [1:0] HOP_READ = 2'h1;
  localparam logic [1:0] HOP_WRITE = 2'h2;
  localparam logic [1:0] HOP_SSI = 2'h3;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_DATA_LSB = 16;
  // Synchroniser bit positions inside the device
  localparam int SY_CS = 3;
  localparam int SY_SCK = 2;
  localparam int SY_MOSI = 1;
  localparam int SY_SSCK = 0;
  localparam logic [3:0] SY_RST = 4'h8;
endpackage

// [hw/aspc_link_if.sv]
// Purpose: Pins between the external master and the sensor port
// Assumes: MISO is pulled low whenever the device does not drive it
// Notes: No clocking block; the bench joins both ends here
`timescale 1ns/10ps
interface aspc_link_if;
  logic cs_b; // SPI select, idle high
  logic sclk; // SPI clock from master
  logic mosi; // Master to device data
  logic miso_o; // Device data out
  logic miso_oe; // Device drives MISO
  logic miso; // Resolved MISO wire
  logic ssck; // SSI clock from master
  logic ssd; // SSI data from device
  // Pull-down when MISO is released
  assign miso = miso_oe ? miso_o : 1'b0;
  modport dev (input cs_b, sclk, mosi, ssck, output miso_o, miso_oe, ssd);
  modport host (output cs_b, sclk, mosi, ssck, input miso, ssd);
endinterface

// [hw/aspc_host.sv]
// Purpose: External master issuing SPI and SSI frames to the sensor
// Assumes: Software port: one-cycle strobes, read data a cycle later
// Notes: Runs SPI in mode 0 from a divider of core_clk
`timescale 1ns/10ps
module aspc_host
  import aspc_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_DEF,
  parameter int NVM_CYC = NVM_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  aspc_link_if.host link,
  input wire logic [1:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata
);
  typedef enum logic [5:0] {
    ASPC_H_IDLE = 6'h01,
    ASPC_H_LEAD = 6'h02,
    ASPC_H_LOW = 6'h04,
    ASPC_H_HIGH = 6'h08,
    ASPC_H_TAIL = 6'h10,
    ASPC_H_GAP = 6'h20
  } aspc_hst_t;
  localparam int WT_W = 24;
  aspc_hst_t st_q, st_d; // Sequencer state
  logic [WT_W-1:0] wt_q, wt_d; // Wait counter
  logic [4:0] bit_q, bit_d; // Clock pulses done
  logic [15:0] tx_q, tx_d; // Outgoing word
  logic [15:0] rx_q, rx_d; // Incoming word
  logic [15:0] reply_q, reply_d; // Last complete frame
  logic [1:0] op_q, op_d; // Operation in flight
  logic second_q, second_d; // Reply frame still due
  logic cs_b_q, cs_b_d, sclk_q, sclk_d, ssck_q, ssck_d, mosi_q, mosi_d;
  logic [1:0] miso_sy_q, ssd_sy_q; // Input synchronisers
  logic [31:0] rdata_q, rdata_d; // Software read data
  logic ssi; // Current op uses SSI
  logic in_bit; // Sampled data bit
  logic [4:0] last_bit; // Final pulse index
  logic [WT_W-1:0] half; // Half clock period

  assign link.cs_b = cs_b_q;
  assign link.sclk = sclk_q;
  assign link.ssck = ssck_q;
  assign link.mosi = mosi_q;
  assign sw_rdata = rdata_q;
  assign ssi = (op_q == HOP_SSI);
  assign in_bit = ssi ? ssd_sy_q[1] : miso_sy_q[1];
  assign last_bit = ssi ? 5'(SSI_CLOCKS - 1) : 5'(FRAME_BITS - 1);
  assign half = WT_W'(HALF_CYC - 1);

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    wt_d = wt_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    reply_d = reply_q;
    op_d = op_q;
    second_d = second_q;
    cs_b_d = cs_b_q;
    sclk_d = sclk_q;
    ssck_d = ssck_q;
    mosi_d = mosi_q;
    case (st_q)
      ASPC_H_IDLE: begin
        // Commands while busy are ignored
        if (sw_wr && sw_addr == HREG_CTRL) begin
          op_d = sw_wdata[1:0];
          bit_d = 5'h00;
          wt_d = half;
          second_d = 1'b0;
          tx_d = 16'h0000;
          if (sw_wdata[1:0] == HOP_READ) begin
            tx_d = {OP_READ, sw_wdata[CTRL_ADDR_LSB +: 5], 8'h00};
            second_d = 1'b1;
          end else if (sw_wdata[1:0] == HOP_WRITE) begin
            tx_d = {OP_WRITE, sw_wdata[CTRL_ADDR_LSB +: 5],
                    sw_wdata[CTRL_DATA_LSB +: 8]};
            second_d = 1'b1;
          end
          if (sw_wdata[1:0] == HOP_SSI) begin
            st_d = ASPC_H_LOW;
          end else begin
            st_d = ASPC_H_LEAD;
            cs_b_d = 1'b0;
            mosi_d = tx_d[15];
          end
        end
      end
      ASPC_H_LEAD: begin
        // Select setup before first edge
        if (wt_q == '0) begin
          st_d = ASPC_H_LOW;
          wt_d = half;
        end else begin
          wt_d = wt_q - 1'b1;
        end
      end
      ASPC_H_LOW: begin
        // Clock low half, then rise
        if (wt_q == '0) begin
          st_d = ASPC_H_HIGH;
          wt_d = half;
          if (ssi) ssck_d = 1'b1;
          else sclk_d = 1'b1;
        end else begin
          wt_d = wt_q - 1'b1;
        end
      end
      ASPC_H_HIGH: begin
        // Sample just before falling edge, then fall
        if (wt_q == '0) begin
          if (!(ssi && bit_q == 5'h00)) rx_d = {rx_q[14:0], in_bit};
          bit_d = bit_q + 1'b1;
          sclk_d = 1'b0;
          ssck_d = 1'b0;
          wt_d = half;
          if (bit_q == last_bit) begin
            st_d = ASPC_H_TAIL;
          end else begin
            st_d = ASPC_H_LOW;
            tx_d = {tx_q[14:0], 1'b0};
            mosi_d = tx_q[14];
          end
        end else begin
          wt_d = wt_q - 1'b1;
        end
      end
      ASPC_H_TAIL: begin
        // Hold after last edge, release select, choose gap
        if (wt_q == '0) begin
          cs_b_d = 1'b1;
          mosi_d = 1'b0;
          reply_d = rx_q;
          st_d = ASPC_H_GAP;
          if (ssi) wt_d = WT_W'(SSI_DEAD_CYC - 1);
          else if (second_q && op_q == HOP_WRITE)
            wt_d = WT_W'(NVM_CYC - 1);
          else if (op_q == HOP_ANGLE) wt_d = WT_W'(IDLE_ANG_CYC - 1);
          else wt_d = WT_W'(IDLE_REG_CYC - 1);
        end else begin
          wt_d = wt_q - 1'b1;
        end
      end
      ASPC_H_GAP: begin
        // Idle gap; start reply frame with zeros out
        if (wt_q != '0) begin
          wt_d = wt_q - 1'b1;
        end else if (second_q) begin
          second_d = 1'b0;
          tx_d = 16'h0000;
          rx_d = 16'h0000;
          bit_d = 5'h00;
          cs_b_d = 1'b0;
          wt_d = half;
          st_d = ASPC_H_LEAD;
        end else begin
          st_d = ASPC_H_IDLE;
        end
      end
      default: st_d = ASPC_H_IDLE;
    endcase
  end

  // Sequencer registers and input synchronisers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ASPC_H_IDLE;
      wt_q <= '0;
      bit_q <= 5'h00;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      reply_q <= 16'h0000;
      op_q <= HOP_ANGLE;
      second_q <= 1'b0;
      cs_b_q <= 1'b1;
      sclk_q <= 1'b0;
      ssck_q <= 1'b0;
      mosi_q <= 1'b0;
      miso_sy_q <= 2'h0;
      ssd_sy_q <= 2'h0;
    end else begin
      st_q <= st_d;
      wt_q <= wt_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      reply_q <= reply_d;
      op_q <= op_d;
      second_q <= second_d;
      cs_b_q <= cs_b_d;
      sclk_q <= sclk_d;
      ssck_q <= ssck_d;
      mosi_q <= mosi_d;
      miso_sy_q <= {miso_sy_q[0], link.miso};
      ssd_sy_q <= {ssd_sy_q[0], link.ssd};
    end
  end

  // Software read data, valid the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sw_rd) begin
      case (sw_addr)
        HREG_STAT: rdata_d = {31'h0000_0000, st_q != ASPC_H_IDLE};
        HREG_REPLY: rdata_d = {16'h0000, reply_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rdata_q <= 32'h0000_0000;
    else rdata_q <= rdata_d;
  end
endmodule

// [hw/aspc_dev.sv]
// Purpose: Sensor end of the SPI and SSI serial ports
// Assumes: Link pins are asynchronous and pass two flip-flops
// Notes: Store array keeps its content across rst_b, as nonvolatile cells
`timescale 1ns/10ps
module aspc_dev
  import aspc_pkg::*;
#(
  parameter int ANGLE_BITS = ANGLE_BITS_DEF,
  parameter int NVM_CYC = NVM_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  aspc_link_if.dev link,
  input wire logic [15:0] angle_in,
  input wire logic field_high_flag,
  input wire logic field_low_flag,
  output logic rot_dir
);
  localparam logic [15:0] ANG_MASK =
    16'(((32'h0000_0001 << ANGLE_BITS) - 32'h0000_0001)
        << (FRAME_BITS - ANGLE_BITS));
  localparam int NW = $clog2(NVM_CYC + 1);
  localparam int TW = $clog2(SSI_TM_CYC + 1);
  localparam int RW = $clog2(REFRESH_CYC + 1);

  logic [3:0] sy1_q, sy2_q, sy3_q; // Pin synchronisers and edge stage
  logic [15:0] buf_q, buf_d; // Angle output buffer
  logic [RW-1:0] ref_q, ref_d; // Refresh divider
  logic [4:0] bit_q, bit_d; // SPI rising edges seen
  logic rise_q, rise_d; // First rising edge done
  logic [15:0] tx_q, tx_d, rx_q, rx_d; // SPI shift words
  logic pend_q, pend_d; // Next frame returns a register
  logic [4:0] paddr_q, paddr_d; // Register for the reply
  logic miso_q, miso_d, moe_q, moe_d; // MISO drive
  logic wr_go; // Full write command received for any register but REG_FIELD
  logic wbusy_q, wbusy_d; // Store write in progress
  logic [NW-1:0] wcnt_q, wcnt_d; // Store write timer
  logic [4:0] waddr_q, waddr_d; // Address being written
  logic [7:0] wdata_q, wdata_d; // Data being written
  logic [7:0] nvm_mem [32]; // Nonvolatile register image
  logic load_q; // Restore pending after reset
  logic rot_q, rot_d; // Rotation direction bit
  logic sbusy_q, sbusy_d; // SSI transfer holds buffer
  logic [15:0] ssh_q, ssh_d; // SSI shift word
  logic ssd_q, ssd_d; // SSI data out
  logic [TW-1:0] tm_q, tm_d; // SSI transfer timeout
  logic cs_fall, cs_rise, cs_low, sck_rise, sck_fall, ss_rise, ss_fall;
  logic [7:0] reg_val; // Register content for reply

  assign link.miso_o = miso_q;
  assign link.miso_oe = moe_q;
  assign link.ssd = ssd_q;
  assign rot_dir = rot_q;

  // Edges from the second and third stages only
  assign cs_fall = sy3_q[SY_CS] & ~sy2_q[SY_CS];
  assign cs_rise = ~sy3_q[SY_CS] & sy2_q[SY_CS];
  assign cs_low = ~sy3_q[SY_CS] & ~sy2_q[SY_CS];
  assign sck_rise = ~sy3_q[SY_SCK] & sy2_q[SY_SCK];
  assign sck_fall = sy3_q[SY_SCK] & ~sy2_q[SY_SCK];
  assign ss_rise = ~sy3_q[SY_SSCK] & sy2_q[SY_SSCK];
  assign ss_fall = sy3_q[SY_SSCK] & ~sy2_q[SY_SSCK];

  // Flags register reads live, others from the store image
  always_comb begin
    reg_val = nvm_mem[paddr_q];
    if (paddr_q == REG_FIELD) begin
      reg_val = 8'h00;
      reg_val[FIELD_HIGH_BIT] = field_high_flag;
      reg_val[FIELD_LOW_BIT] = field_low_flag;
    end
  end

  // Buffer refresh, frozen while SPI selected or SSI busy
  always_comb begin
    buf_d = buf_q;
    ref_d = ref_q;
    if (ref_q == RW'(REFRESH_CYC - 1)) begin
      ref_d = '0;
      if (!(cs_low || cs_fall || sbusy_q))
        buf_d = angle_in & ANG_MASK;
    end else begin
      ref_d = ref_q + 1'b1;
    end
  end

  // SPI framing: mode found from the edge order after select
  always_comb begin
    bit_d = bit_q;
    rise_d = rise_q;
    tx_d = tx_q;
    rx_d = rx_q;
    pend_d = pend_q;
    paddr_d = paddr_q;
    miso_d = miso_q;
    moe_d = moe_q;
    wr_go = 1'b0;
    if (cs_fall) begin
      bit_d = 5'h00;
      rise_d = 1'b0;
      rx_d = 16'h0000;
      tx_d = pend_q ? {reg_val, 8'h00} : buf_q;
      miso_d = tx_d[15];
      moe_d = 1'b1;
    end else if (cs_low) begin
      if (sck_rise && bit_q != 5'(FRAME_BITS)) begin
        rx_d = {rx_q[14:0], sy2_q[SY_MOSI]};
        bit_d = bit_q + 1'b1;
        rise_d = 1'b1;
      end
      // Mode 3 leading fall comes before any rise and is skipped
      if (sck_fall && rise_q) begin
        tx_d = {tx_q[14:0], 1'b0};
        miso_d = tx_q[14];
      end
    end else if (cs_rise) begin
      moe_d = 1'b0;
      miso_d = 1'b0;
      // Short frames leave the pending reply and its address as they were
      if (bit_q == 5'(FRAME_BITS)) begin
        pend_d = 1'b0;
        paddr_d = rx_q[ADDR_MSB:ADDR_LSB];
        if (rx_q[OP_MSB -: 3] == OP_READ) pend_d = 1'b1;
        if (rx_q[OP_MSB -: 3] == OP_WRITE) begin
          pend_d = 1'b1;
          wr_go = (rx_q[ADDR_MSB:ADDR_LSB] != REG_FIELD);
        end
      end
    end
  end

  // Store write timer; reply before expiry sees old value
  always_comb begin
    wbusy_d = wbusy_q;
    wcnt_d = wcnt_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    rot_d = rot_q;
    if (wr_go) begin
      wbusy_d = 1'b1;
      // Finish early by the pin lag, so that a reply sent after the full
      // store time already sees the new value; needs NVM_CYC of 4 or more
      wcnt_d = NW'(NVM_CYC - 4);
      waddr_d = rx_q[ADDR_MSB:ADDR_LSB];
      wdata_d = rx_q[7:0];
    end else if (wbusy_q) begin
      if (wcnt_q == '0) begin
        wbusy_d = 1'b0;
        if (waddr_q == REG_ROT_DIR) rot_d = wdata_q[ROT_DIR_BIT];
      end else begin
        wcnt_d = wcnt_q - 1'b1;
      end
    end
    if (load_q) rot_d = nvm_mem[REG_ROT_DIR][ROT_DIR_BIT];
  end

  // SSI: first rising edge is the dummy, data on later rises
  always_comb begin
    sbusy_d = sbusy_q;
    ssh_d = ssh_q;
    ssd_d = ssd_q;
    tm_d = tm_q;
    if (ss_rise || ss_fall) begin
      tm_d = TW'(SSI_TM_CYC - 1);
      if (ss_rise && !sbusy_q) begin
        sbusy_d = 1'b1;
        ssh_d = buf_q;
      end else if (ss_rise) begin
        ssd_d = ssh_q[15];
        ssh_d = {ssh_q[14:0], 1'b0};
      end
    end else if (sbusy_q) begin
      if (tm_q == '0) begin
        sbusy_d = 1'b0;
        ssd_d = 1'b0;
      end else begin
        tm_d = tm_q - 1'b1;
      end
    end
  end

  // Nonvolatile image, no reset so content survives it
  always_ff @(posedge core_clk) begin
    if (wbusy_q && wcnt_q == '0 && !wr_go) nvm_mem[waddr_q] <= wdata_q;
  end

  // All state registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_q <= SY_RST;
      sy2_q <= SY_RST;
      sy3_q <= SY_RST;
      buf_q <= 16'h0000;
      ref_q <= '0;
      bit_q <= 5'h00;
      rise_q <= 1'b0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      pend_q <= 1'b0;
      paddr_q <= 5'h00;
      miso_q <= 1'b0;
      moe_q <= 1'b0;
      wbusy_q <= 1'b0;
      wcnt_q <= '0;
      waddr_q <= 5'h00;
      wdata_q <= 8'h00;
      load_q <= 1'b1;
      rot_q <= 1'b0;
      sbusy_q <= 1'b0;
      ssh_q <= 16'h0000;
      ssd_q <= 1'b0;
      tm_q <= '0;
    end else begin
      sy1_q <= {link.cs_b, link.sclk, link.mosi, link.ssck};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      buf_q <= buf_d;
      ref_q <= ref_d;
      bit_q <= bit_d;
      rise_q <= rise_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      pend_q <= pend_d;
      paddr_q <= paddr_d;
      miso_q <= miso_d;
      moe_q <= moe_d;
      wbusy_q <= wbusy_d;
      wcnt_q <= wcnt_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      load_q <= 1'b0;
      rot_q <= rot_d;
      sbusy_q <= sbusy_d;
      ssh_q <= ssh_d;
      ssd_q <= ssd_d;
      tm_q <= tm_d;
    end
  end
endmodule

// [bench/aspc_asserts.sv]
// Purpose: Link checks between the host end and the sensor end
// Assumes: Host runs mode 0, 16-clock frames; at most 14 angle bits
// Notes: Sees the interface wires only; instanced beside the link
`timescale 1ns/10ps
module aspc_asserts
  import aspc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso,
  input wire logic ssck,
  input wire logic ssd
);
  logic sclk_q; // Last sampled SPI clock
  logic ssck_q; // Last sampled SSI clock
  logic [4:0] rise_q; // SPI clock rises in this frame
  logic [4:0] rise_d;
  logic [10:0] quiet_q; // Cycles since the SSI clock moved
  logic [10:0] quiet_d;
  // Counts rises per frame and SSI quiet time
  always_comb begin
    rise_d = rise_q;
    quiet_d = quiet_q;
    if (cs_b) begin
      rise_d = 5'h00;
    end else if (sclk && !sclk_q) begin
      rise_d = rise_q + 5'h01;
    end
    if (ssck != ssck_q) begin
      quiet_d = 11'h000;
    end else if (quiet_q != 11'h7ff) begin
      quiet_d = quiet_q + 11'h001;
    end
  end
  // Registers the helper state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      ssck_q <= 1'b0;
      rise_q <= 5'h00;
      quiet_q <= 11'h000;
    end else begin
      sclk_q <= sclk;
      ssck_q <= ssck;
      rise_q <= rise_d;
      quiet_q <= quiet_d;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_sel_drives_miso: assert property (!cs_b [*6] |-> miso_oe)
    else $error("MISO not driven while selected");
  a_idle_releases: assert property (cs_b [*6] |-> !miso_oe)
    else $error("MISO driven while deselected");
  a_miso_steady: assert property (sclk [*7] |-> $stable(miso_o))
    else $error("MISO moved while SPI clock high");
  a_tail_zero: assert property (
    !cs_b && sclk && sclk_q && rise_q >= 5'h0f |-> !miso)
    else $error("Trailing reply bit not zero");
  a_frame_len: assert property ($rose(cs_b) |-> rise_q == 5'h10)
    else $error("Frame without sixteen clocks");
  a_idle_gap: assert property ($rose(cs_b) |-> cs_b [*8])
    else $error("Select idle time too short");
  a_clk_idle_low: assert property (cs_b |-> !sclk)
    else $error("SPI clock not idle low");
  a_dummy_quiet: assert property (
    $rose(ssck) && quiet_q > 11'h064 |-> !ssd [*8])
    else $error("SSI data sent on dummy clock");
  a_ssd_hold: assert property ($fell(ssck) |-> $stable(ssd) [*8])
    else $error("SSI data moved after falling edge");
  a_ssd_release: assert property (quiet_q == 11'h514 |-> !ssd)
    else $error("SSI data not released after timeout");
  c_spi_frame: cover property ($rose(cs_b) && rise_q == 5'h10);
  c_ssi_read: cover property ($rose(ssck) && quiet_q > 11'h064);
  c_miso_high: cover property (miso_oe && miso);
endmodule

// [bench/angle_sensor_serial_port_test.sv]
// Purpose: Bench for the angle sensor serial port, both ends joined
// Assumes: Store delay shortened; second sensor driven by raw frames
// Notes: Second link carries mode 3 and cut-short frames
`timescale 1ns/10ps
module angle_sensor_serial_port_test;
  import aspc_pkg::*;
  localparam int NV = 200; // Shortened store delay
  localparam int AB = 14; // Useful angle bits
  logic core_clk = 1'b0; // System clock
  logic rst_b = 1'b0; // Reset, active low
  logic [1:0] sw_addr = 2'h0; // Software port
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic [15:0] angle_in = 16'h0000; // Front-end angle
  logic field_high_flag = 1'b0; // Field level flags
  logic field_low_flag = 1'b0;
  logic rot_dir; // Direction out of the first sensor
  logic [15:0] got2 = 16'h0000; // Result seen by the raw driver
  logic got2_v = 1'b0;
  logic [15:0] expq[$]; // Expected results, oldest first
  logic rep_q = 1'b0; // Reply read pending
  int seed = 30373;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  aspc_link_if lk();
  aspc_link_if lk2();
  aspc_host #(.NVM_CYC(NV)) u_aspc_host (.core_clk(core_clk),
    .rst_b(rst_b), .link(lk), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  aspc_dev #(.ANGLE_BITS(AB), .NVM_CYC(NV)) u_aspc_dev (
    .core_clk(core_clk), .rst_b(rst_b), .link(lk), .angle_in(angle_in),
    .field_high_flag(field_high_flag), .field_low_flag(field_low_flag),
    .rot_dir(rot_dir));
  aspc_dev #(.ANGLE_BITS(AB), .NVM_CYC(NV)) u_aspc_dev_2 (
    .core_clk(core_clk), .rst_b(rst_b), .link(lk2), .angle_in(angle_in),
    .field_high_flag(field_high_flag), .field_low_flag(field_low_flag),
    .rot_dir());
  aspc_asserts u_aspc_asserts (.core_clk(core_clk), .rst_b(rst_b),
    .cs_b(lk.cs_b), .sclk(lk.sclk), .miso_o(lk.miso_o),
    .miso_oe(lk.miso_oe), .miso(lk.miso), .ssck(lk.ssck), .ssd(lk.ssd));
  // Clock generator
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Compares one value and counts it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Keeps only the useful angle bits
  function automatic logic [15:0] msk(input logic [15:0] a);
    return a & ~(16'hffff >> AB);
  endfunction
  // Prints the counts and the verdict
  task automatic end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Software port write and read cycles
  task automatic sw_w(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // One host operation: start, poll until idle, read the reply
  task automatic sw_op(input logic [1:0] op, input logic [4:0] a,
      input logic [7:0] d, input logic [15:0] exp);
    logic [31:0] s;
    int n;
    sw_w(HREG_CTRL, {8'h00, d, 3'h0, a, 6'h00, op});
    n = 0;
    s = 32'h0000_0001;
    while (s[0] !== 1'b0 && n < 5000) begin
      sw_r(HREG_STAT, s);
      n++;
    end
    // A host that never goes idle ends the run as a failure
    if (s[0] !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
    expq.push_back(exp);
    sw_r(HREG_REPLY, s);
  endtask
  // Hands a raw result to the watcher
  task automatic note2(input logic [15:0] r);
    got2 = r;
    got2_v = 1'b1;
    #1 got2_v = 1'b0;
  endtask
  // Raw SPI frame on the second link, nb clocks, idle level cp
  task automatic spi2(input logic [15:0] w, input int nb, input logic cp,
      input logic ck);
    logic [15:0] r;
    r = 16'h0000;
    @(posedge core_clk);
    lk2.sclk <= cp;
    repeat (4) @(posedge core_clk);
    lk2.cs_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    // Link clock of 160 ns, twice the host's rate
    for (int i = 0; i < nb; i++) begin
      lk2.sclk <= 1'b0;
      lk2.mosi <= w[15 - i];
      repeat (4) @(posedge core_clk);
      lk2.sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      r = {r[14:0], lk2.miso};
    end
    if (!cp) lk2.sclk <= 1'b0;
    repeat (4) @(posedge core_clk);
    lk2.cs_b <= 1'b1;
    lk2.mosi <= 1'b0;
    if (ck) note2(r);
    repeat (50) @(posedge core_clk);
  endtask
  // Watchers: oldest note against each result
  always @(posedge core_clk) begin
    rep_q <= sw_rd && sw_addr == HREG_REPLY;
    if (rep_q) check(sw_rdata[15:0], expq.pop_front());
  end
  always @(posedge got2_v) check(got2, expq.pop_front());
  // Cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    logic [15:0] a;
    logic [7:0] d1;
    lk2.cs_b = 1'b1;
    lk2.sclk = 1'b0;
    lk2.mosi = 1'b0;
    lk2.ssck = 1'b0;
    a = $random(seed);
    d1 = $random(seed);
    angle_in = a;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    field_high_flag <= $random(seed);
    field_low_flag <= $random(seed);
    repeat (4) @(posedge core_clk);
    sw_op(HOP_WRITE, REG_ROT_DIR, 8'h80, 16'h8000);
    sw_op(HOP_READ, REG_FIELD, 8'h00,
      {field_high_flag, field_low_flag, 14'h0000});
    sw_op(HOP_ANGLE, 5'h00, 8'h00, msk(a));
    sw_op(HOP_SSI, 5'h00, 8'h00, msk(a));
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    expq.push_back(16'h0001);
    note2({15'h0000, rot_dir});
    sw_op(HOP_READ, REG_ROT_DIR, 8'h00, 16'h8000);
    expq.push_back(msk(a));
    spi2(16'h0000, 16, 1'b1, 1'b1);
    expq.push_back({8'h00, a[15:8]});
    spi2(16'h0000, 8, 1'b0, 1'b1);
    spi2({OP_WRITE, 5'h05, d1}, 16, 1'b1, 1'b0);
    #5000;
    expq.push_back({d1, 8'h00});
    spi2(16'h0000, 16, 1'b1, 1'b1);
    spi2({OP_WRITE, 5'h05, ~d1}, 8, 1'b0, 1'b0);
    #5000;
    spi2({OP_READ, 5'h05, 8'h00}, 16, 1'b0, 1'b0);
    expq.push_back({d1, 8'h00});
    spi2(16'h0000, 16, 1'b0, 1'b1);
    spi2({OP_WRITE, 5'h05, ~d1}, 16, 1'b0, 1'b0);
    expq.push_back({d1, 8'h00});
    spi2(16'h0000, 16, 1'b0, 1'b1);
    #5000;
    spi2({OP_READ, 5'h05, 8'h00}, 16, 1'b1, 1'b0);
    expq.push_back({~d1, 8'h00});
    spi2(16'h0000, 16, 1'b1, 1'b1);
    expq.push_back(msk(a));
    fork
      spi2(16'h0000, 16, 1'b1, 1'b1);
      begin
        repeat (40) @(posedge core_clk);
        a = $random(seed);
        angle_in <= a;
      end
    join
    #2000;
    expq.push_back(msk(a));
    spi2(16'h0000, 16, 1'b1, 1'b1);
    end_sim();
  end
endmodule
